// ===== card_detect_pad_defines.svh
`ifndef CARD_DETECT_PAD_DEFINES_SVH
`define CARD_DETECT_PAD_DEFINES_SVH

// =====================================================================
// Register byte offsets
`define IRQ_STATUS_OFS 12'h008
`define FIFO_DATA_PORT_OFS 12'h00c
`define CARD_PIN_STATE_OFS 12'h010
`define PAD_IO_CONTROL_OFS 12'h014
`define ADDR_DECODE_W 12

// =====================================================================
// Interrupt status fields
`define BUSY_DONE_IRQ_BIT 6

// =====================================================================
// Card pin state fields
`define DETECT_ON_BIT 0
`define DETECT_INPUT_ON_BIT 1
`define DETECT_INPUT_OUT_ON_BIT 2
`define DETECT_PIN_LEVEL_BIT 3
`define PIN_CHANGED_BIT 4
`define DETECT_FILTER_LEN_LSB 12
`define DETECT_FILTER_LEN_MSB 15
`define CARD_DAT_LSB 16
`define CARD_DAT_MSB 19
`define CARD_CMD_BIT 24

// =====================================================================
// Pad control fields and reset values
`define CMD_CLK_DRIVE_LSB 0
`define CMD_CLK_DRIVE_MSB 2
`define DATA_PAD_DRIVE_LSB 3
`define DATA_PAD_DRIVE_MSB 5
`define CMD_CLK_SLEW_BIT 6
`define DATA_PAD_SLEW_BIT 7
`define INSERT_PULL_LSB 8
`define INSERT_PULL_MSB 9
`define RESPONSE_EDGE_BIT 15
`define LATCH_DELAY_LSB 24
`define LATCH_DELAY_MSB 31
`define CMD_CLK_DRIVE_RST 3'h3
`define DATA_PAD_DRIVE_RST 3'h0
`define SLEW_RST 1'h1
`define INSERT_PULL_RST 2'h2
`define RESPONSE_EDGE_RST 1'h0
`define LATCH_DELAY_RST 8'h02

// =====================================================================
// Timing
`define CLK_HZ 50000000
`define FILTER_CLK_HZ 32768
`define FILTER_TICK_CYCLES (`CLK_HZ / `FILTER_CLK_HZ)
`define DETECT_SETTLE_CYCLES 32
`define FILTER_BASE_TICKS 32

`endif

// ===== card_detect_pad_pkg.sv
package card_detect_pad_pkg;

  // Pad configuration handed to the IO ring
  typedef struct packed {
    logic [2:0] cmd_clk_drive_sel;
    logic [2:0] data_pad_drive_sel;
    logic cmd_clk_slew_sel;
    logic data_pad_slew_sel;
    logic [1:0] insert_pin_pull_sel;
    logic response_edge_sel;
    logic [7:0] data_latch_delay;
  } pad_ctrl_t;

  // Command completion report from the command sequencer
  typedef struct packed {
    logic done;
    logic rsp_busy;
    logic multi_block;
  } cmd_report_t;

  // Card detection debounce state
  typedef enum logic [1:0] {
    DET_OFF,
    DET_SETTLE,
    DET_WATCH
  } detect_state_t;

endpackage

// ===== card_detect_pad.sv
`timescale 1ns/1ps
`include "card_detect_pad_defines.svh"
module card_detect_pad
  import card_detect_pad_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite slave
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Command sequencer report, same clock
  input wire cmd_report_t i_cmd_report,
  // Controller FIFO, show-ahead read side
  output logic o_fifo_push,
  output logic [31:0] o_fifo_push_data,
  output logic o_fifo_pop,
  input wire logic [31:0] i_fifo_head_data,
  // Card pins, asynchronous
  input wire logic i_insert_sense_pin,
  input wire logic [3:0] i_card_dat,
  input wire logic i_card_cmd,
  // Pad and latch controls
  output pad_ctrl_t o_pad_ctrl,
  output logic o_detect_input_on,
  output logic o_detect_input_out_on,
  output logic [8:0] o_rise_latch_point,
  output logic [9:0] o_fall_latch_half_point
);

  // ===================================================================
  // Pin synchronisers
  logic [5:0] pin_meta_reg; // First stage, read only by second
  logic [5:0] pin_sync_reg; // Safe copies
  logic insert_sync;
  logic [3:0] dat_sync;
  logic cmd_sync;

  // Two flops per pin before any logic looks at it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
    end else begin
      pin_meta_reg <= {i_card_cmd, i_card_dat, i_insert_sense_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign insert_sync = pin_sync_reg[0];
  assign dat_sync = pin_sync_reg[4:1];
  assign cmd_sync = pin_sync_reg[5];

  // ===================================================================
  // AXI4-Lite slave
  logic aw_have_reg; // Address latched
  logic w_have_reg; // Data latched
  logic [`ADDR_DECODE_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire; // Both halves present, commit now
  logic rd_fire; // Read address taken
  logic [`ADDR_DECODE_W-1:0] raddr;
  logic [31:0] rd_word; // Decoded read value

  assign wr_fire = aw_have_reg && w_have_reg && !o_s_axi_bvalid;
  assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign raddr = i_s_axi_araddr[`ADDR_DECODE_W-1:0];

  // Address and data halves may arrive in either order
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have_reg <= 1'b1;
        waddr_reg <= i_s_axi_awaddr[`ADDR_DECODE_W-1:0];
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Ready flags held as flops so every output is registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_arready <= 1'b0;
    end else begin
      o_s_axi_awready <= !aw_have_reg && !(i_s_axi_awvalid && o_s_axi_awready);
      o_s_axi_wready <= !w_have_reg && !(i_s_axi_wvalid && o_s_axi_wready);
      // One read in flight at most
      o_s_axi_arready <= !o_s_axi_rvalid && !rd_fire;
    end
  end

  // Write response, OKAY always; unmapped writes are dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= 2'h0;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ===================================================================
  // Register state
  logic detect_on_reg;
  logic detect_input_on_reg;
  logic detect_input_out_on_reg;
  logic [3:0] detect_filter_len_reg;
  logic pin_changed_reg; // Sticky insertion/removal flag
  logic busy_done_irq_reg; // Sticky busy completion flag
  logic accepted_level_reg; // Last debounced sense level
  logic set_pin_changed; // Debounce accepted a new level
  logic set_busy_done; // Dat0 released after busy command
  logic wr_pin_state;
  logic wr_pad;

  assign wr_pin_state = wr_fire && (waddr_reg == `CARD_PIN_STATE_OFS);
  assign wr_pad = wr_fire && (waddr_reg == `PAD_IO_CONTROL_OFS);

  // Detection control bits, low byte lane; filter length in byte lane 1
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      detect_on_reg <= 1'b0;
      detect_input_on_reg <= 1'b0;
      detect_input_out_on_reg <= 1'b0;
      detect_filter_len_reg <= 4'h0;
    end else if (wr_pin_state) begin
      if (wstrb_reg[0]) begin
        detect_on_reg <= wdata_reg[`DETECT_ON_BIT];
        detect_input_on_reg <= wdata_reg[`DETECT_INPUT_ON_BIT];
        detect_input_out_on_reg <= wdata_reg[`DETECT_INPUT_OUT_ON_BIT];
      end
      if (wstrb_reg[1]) begin
        detect_filter_len_reg <= wdata_reg[`DETECT_FILTER_LEN_MSB:`DETECT_FILTER_LEN_LSB];
      end
    end
  end

  // Pad configuration fields
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_ctrl.cmd_clk_drive_sel <= `CMD_CLK_DRIVE_RST;
      o_pad_ctrl.data_pad_drive_sel <= `DATA_PAD_DRIVE_RST;
      o_pad_ctrl.cmd_clk_slew_sel <= `SLEW_RST;
      o_pad_ctrl.data_pad_slew_sel <= `SLEW_RST;
      o_pad_ctrl.insert_pin_pull_sel <= `INSERT_PULL_RST;
      o_pad_ctrl.response_edge_sel <= `RESPONSE_EDGE_RST;
      o_pad_ctrl.data_latch_delay <= `LATCH_DELAY_RST;
    end else if (wr_pad) begin
      if (wstrb_reg[0]) begin
        o_pad_ctrl.cmd_clk_drive_sel <= wdata_reg[`CMD_CLK_DRIVE_MSB:`CMD_CLK_DRIVE_LSB];
        o_pad_ctrl.data_pad_drive_sel <= wdata_reg[`DATA_PAD_DRIVE_MSB:`DATA_PAD_DRIVE_LSB];
        o_pad_ctrl.cmd_clk_slew_sel <= wdata_reg[`CMD_CLK_SLEW_BIT];
        o_pad_ctrl.data_pad_slew_sel <= wdata_reg[`DATA_PAD_SLEW_BIT];
      end
      if (wstrb_reg[1]) begin
        o_pad_ctrl.insert_pin_pull_sel <= wdata_reg[`INSERT_PULL_MSB:`INSERT_PULL_LSB];
        o_pad_ctrl.response_edge_sel <= wdata_reg[`RESPONSE_EDGE_BIT];
      end
      if (wstrb_reg[3]) begin
        // Zero or above the divider ratio is software's fault; stored as is
        o_pad_ctrl.data_latch_delay <= wdata_reg[`LATCH_DELAY_MSB:`LATCH_DELAY_LSB];
      end
    end
  end

  // Capture points in base clocks and half base clocks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rise_latch_point <= 9'h003;
      o_fall_latch_half_point <= 10'h005;
    end else begin
      o_rise_latch_point <= {1'b0, o_pad_ctrl.data_latch_delay} + 9'h001;
      // Falling capture half a base clock ahead of rising
      o_fall_latch_half_point <= {1'b0, o_pad_ctrl.data_latch_delay, 1'b0} + 10'h001;
    end
  end

  // Detection enables mirrored to the pad
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_detect_input_on <= 1'b0;
      o_detect_input_out_on <= 1'b0;
    end else begin
      o_detect_input_on <= detect_input_on_reg;
      o_detect_input_out_on <= detect_input_out_on_reg;
    end
  end

  // ===================================================================
  // FIFO data port
  // Show-ahead head word is sampled in the cycle the read is taken and returned the next cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_push <= 1'b0;
      o_fifo_push_data <= 32'h0000_0000;
      o_fifo_pop <= 1'b0;
    end else begin
      // Whole word only; partial strobes still push all 32 bits
      o_fifo_push <= wr_fire && (waddr_reg == `FIFO_DATA_PORT_OFS);
      o_fifo_push_data <= wdata_reg;
      o_fifo_pop <= rd_fire && (raddr == `FIFO_DATA_PORT_OFS);
    end
  end

  // ===================================================================
  // Card detection debounce
  detect_state_t det_state_reg;
  logic [5:0] settle_cnt_reg; // Controller cycles since enable
  logic [10:0] tick_div_reg; // Slow tick divider
  logic slow_tick; // One pulse per slow period
  logic [5:0] filter_cnt_reg; // Slow ticks of stable new level
  logic [5:0] filter_target;
  logic detect_live;

  assign detect_live = detect_on_reg && detect_input_on_reg;
  assign slow_tick = (tick_div_reg == 11'(`FILTER_TICK_CYCLES - 1));
  assign filter_target = 6'(`FILTER_BASE_TICKS) + {2'h0, detect_filter_len_reg};

  // Free-running slow tick divider
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_div_reg <= 11'h000;
    end else if (slow_tick) begin
      tick_div_reg <= 11'h000;
    end else begin
      tick_div_reg <= tick_div_reg + 11'h001;
    end
  end

  // Settle after enabling, then watch the level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_state_reg <= DET_OFF;
      settle_cnt_reg <= 6'h00;
    end else begin
      unique case (det_state_reg)
        DET_OFF: begin
          settle_cnt_reg <= 6'h00;
          if (detect_live) begin
            det_state_reg <= DET_SETTLE;
          end
        end
        DET_SETTLE: begin
          settle_cnt_reg <= settle_cnt_reg + 6'h01;
          if (!detect_live) begin
            det_state_reg <= DET_OFF;
          end else if (settle_cnt_reg == 6'(`DETECT_SETTLE_CYCLES - 1)) begin
            det_state_reg <= DET_WATCH;
          end
        end
        DET_WATCH: begin
          // Removal is caught with enables simply left on
          if (!detect_live) begin
            det_state_reg <= DET_OFF;
          end
        end
      endcase
    end
  end

  // Filter: a new level must hold for the whole interval
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filter_cnt_reg <= 6'h00;
      accepted_level_reg <= 1'b0;
    end else if (det_state_reg != DET_WATCH || insert_sync == accepted_level_reg) begin
      filter_cnt_reg <= 6'h00;
    end else if (slow_tick) begin
      if (filter_cnt_reg + 6'h01 >= filter_target) begin
        filter_cnt_reg <= 6'h00;
        accepted_level_reg <= insert_sync;
      end else begin
        filter_cnt_reg <= filter_cnt_reg + 6'h01;
      end
    end
  end

  assign set_pin_changed = (det_state_reg == DET_WATCH) && slow_tick &&
                           (insert_sync != accepted_level_reg) &&
                           (filter_cnt_reg + 6'h01 >= filter_target);

  // Sticky change flag; a new change beats the read clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_changed_reg <= 1'b0;
    end else if (set_pin_changed) begin
      pin_changed_reg <= 1'b1;
    end else if (rd_fire && raddr == `CARD_PIN_STATE_OFS) begin
      pin_changed_reg <= 1'b0;
    end
  end

  // ===================================================================
  // Busy response completion
  logic busy_wait_reg; // Waiting for dat0 to leave busy

  // Multi-block commands never arm; the stop that follows does
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_wait_reg <= 1'b0;
    end else if (i_cmd_report.done && i_cmd_report.rsp_busy &&
                 !i_cmd_report.multi_block) begin
      busy_wait_reg <= 1'b1;
    end else if (busy_wait_reg && dat_sync[0]) begin
      busy_wait_reg <= 1'b0;
    end
  end

  // CRC outcome is not looked at: completion alone counts
  assign set_busy_done = busy_wait_reg && dat_sync[0];

  // Sticky irq; a set in the read cycle survives
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_done_irq_reg <= 1'b0;
    end else if (set_busy_done) begin
      busy_done_irq_reg <= 1'b1;
    end else if (rd_fire && raddr == `IRQ_STATUS_OFS) begin
      busy_done_irq_reg <= 1'b0;
    end
  end

  // ===================================================================
  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (raddr)
      `IRQ_STATUS_OFS: rd_word[`BUSY_DONE_IRQ_BIT] = busy_done_irq_reg;
      `FIFO_DATA_PORT_OFS: rd_word = i_fifo_head_data;
      `CARD_PIN_STATE_OFS: begin
        rd_word[`DETECT_ON_BIT] = detect_on_reg;
        rd_word[`DETECT_INPUT_ON_BIT] = detect_input_on_reg;
        rd_word[`DETECT_INPUT_OUT_ON_BIT] = detect_input_out_on_reg;
        rd_word[`DETECT_PIN_LEVEL_BIT] = insert_sync;
        rd_word[`PIN_CHANGED_BIT] = pin_changed_reg;
        rd_word[`DETECT_FILTER_LEN_MSB:`DETECT_FILTER_LEN_LSB] = detect_filter_len_reg;
        rd_word[`CARD_DAT_MSB:`CARD_DAT_LSB] = dat_sync;
        rd_word[`CARD_CMD_BIT] = cmd_sync;
      end
      `PAD_IO_CONTROL_OFS: begin
        rd_word[`CMD_CLK_DRIVE_MSB:`CMD_CLK_DRIVE_LSB] = o_pad_ctrl.cmd_clk_drive_sel;
        rd_word[`DATA_PAD_DRIVE_MSB:`DATA_PAD_DRIVE_LSB] = o_pad_ctrl.data_pad_drive_sel;
        rd_word[`CMD_CLK_SLEW_BIT] = o_pad_ctrl.cmd_clk_slew_sel;
        rd_word[`DATA_PAD_SLEW_BIT] = o_pad_ctrl.data_pad_slew_sel;
        rd_word[`INSERT_PULL_MSB:`INSERT_PULL_LSB] = o_pad_ctrl.insert_pin_pull_sel;
        rd_word[`RESPONSE_EDGE_BIT] = o_pad_ctrl.response_edge_sel;
        rd_word[`LATCH_DELAY_MSB:`LATCH_DELAY_LSB] = o_pad_ctrl.data_latch_delay;
      end
      default: rd_word = 32'h0000_0000; // Unmapped reads as zero
    endcase
  end

  // Read data channel, OKAY always
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= 2'h0;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== card_detect_pad_properties.sv
`timescale 1ns/1ps
// ====================
// Port checks for the detect and pad block
module card_detect_pad_properties
  import card_detect_pad_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic o_fifo_push,
  input wire logic [31:0] o_fifo_push_data,
  input wire logic o_fifo_pop,
  input wire logic [31:0] i_fifo_head_data,
  input wire pad_ctrl_t o_pad_ctrl,
  input wire logic o_detect_input_on,
  input wire logic [8:0] o_rise_latch_point,
  input wire logic [9:0] o_fall_latch_half_point
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic wr_hs; // Both write channels taken at once
  logic rd_hs; // Read address taken
  logic [7:0] dly; // Current latch delay
  assign wr_hs = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  assign rd_hs = i_s_axi_arvalid && o_s_axi_arready;
  assign dly = o_pad_ctrl.data_latch_delay;
  // ====================
  // Bus and data port
  property p_wr_resp;
    wr_hs |-> ##2 o_s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_push;
    wr_hs && i_s_axi_awaddr[11:0] == 12'h00c |-> ##2 o_fifo_push &&
      o_fifo_push_data == $past(i_s_axi_wdata, 2);
  endproperty
  a_push: assert property (p_push) else $error("data port push wrong");
  property p_pop;
    rd_hs && i_s_axi_araddr[11:0] == 12'h00c |=> o_fifo_pop && o_s_axi_rvalid &&
      o_s_axi_rdata == $past(i_fifo_head_data);
  endproperty
  a_pop: assert property (p_pop) else $error("data port pop wrong");
  // ====================
  // Pad controls; latch points follow a settled delay
  property p_rise;
    dly == $past(dly) && dly == $past(dly, 2) |-> o_rise_latch_point == {1'h0, dly} + 9'h1;
  endproperty
  a_rise: assert property (p_rise) else $error("rise latch point wrong");
  property p_fall;
    dly == $past(dly) && dly == $past(dly, 2) |->
      o_fall_latch_half_point == {1'h0, dly, 1'h0} + 10'h1;
  endproperty
  a_fall: assert property (p_fall) else $error("fall latch point wrong");
  property p_pad_wr;
    wr_hs && i_s_axi_awaddr[11:0] == 12'h014 |-> ##3 dly == $past(i_s_axi_wdata[31:24], 3) &&
      o_pad_ctrl.insert_pin_pull_sel == $past(i_s_axi_wdata[9:8], 3);
  endproperty
  a_pad_wr: assert property (p_pad_wr) else $error("pad write lost");
  property p_detect_ctl;
    wr_hs && i_s_axi_awaddr[11:0] == 12'h010 |-> ##3 o_detect_input_on == $past(i_s_axi_wdata[1], 3);
  endproperty
  a_detect_ctl: assert property (p_detect_ctl) else $error("input enable lost");
  property p_reset_pad;
    $rose(i_rst_n) |-> o_pad_ctrl == 19'h31c02;
  endproperty
  a_reset_pad: assert property (p_reset_pad) else $error("pad reset value wrong");
endmodule

bind card_detect_pad card_detect_pad_properties u_props (.i_clk, .i_rst_n, .i_s_axi_awaddr,
  .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wvalid, .o_s_axi_wready,
  .o_s_axi_bvalid, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
  .o_s_axi_rvalid, .o_fifo_push, .o_fifo_push_data, .o_fifo_pop, .i_fifo_head_data,
  .o_pad_ctrl, .o_detect_input_on, .o_rise_latch_point, .o_fall_latch_half_point);

// ===== card_model.sv
`timescale 1ns/1ps
// ====================
// Memory card stand-in: sense pin and busy on data line 0
module card_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_present,
  input wire logic i_busy_go,
  input wire logic [7:0] i_busy_len,
  output logic o_sense,
  output logic [3:0] o_dat,
  output logic o_cmd
);
  logic [7:0] busy_reg; // Busy cycles left
  // Busy length is set by the bench, which keeps it at 20 cycles throughout
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 8'h0;
    end else if (i_busy_go) begin
      busy_reg <= i_busy_len;
    end else if (busy_reg != 8'h0) begin
      busy_reg <= busy_reg - 8'h1;
    end
  end
  // Idle lines sit at their pull-up level
  assign o_dat = {3'h7, busy_reg == 8'h0};
  assign o_cmd = 1'h1;
  assign o_sense = i_present;
endmodule

// ===== card_detect_pad_tb_top.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench
module card_detect_pad_tb_top
  import card_detect_pad_pkg::*;
;
  logic i_clk = 1'h0, i_rst_n = 1'h0;
  logic [31:0] i_s_axi_awaddr = 32'h0, i_s_axi_wdata = 32'h0, i_s_axi_araddr = 32'h0;
  logic [31:0] i_fifo_head_data = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  cmd_report_t i_cmd_report = 3'h0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic o_fifo_push, o_fifo_pop, o_detect_input_on, o_detect_input_out_on;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata, o_fifo_push_data;
  logic [8:0] o_rise_latch_point;
  logic [9:0] o_fall_latch_half_point;
  pad_ctrl_t o_pad_ctrl;
  logic i_insert_sense_pin, i_card_cmd;
  logic [3:0] i_card_dat;
  logic present = 1'h0, busy_go = 1'h0; // Card stimulus
  logic [7:0] busy_len = 8'h14;
  int mismatches = 0, n_checks = 0, cyc = 0;

  card_detect_pad u_dut (.*);
  card_model u_card (.i_clk, .i_rst_n, .i_present(present), .i_busy_go(busy_go),
    .i_busy_len(busy_len), .o_sense(i_insert_sense_pin), .o_dat(i_card_dat), .o_cmd(i_card_cmd));

  initial begin
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;

  // ====================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Channels released as each is taken; bounded wait for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_s_axi_awaddr <= {20'h0, a};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (o_s_axi_bvalid !== 1'h1 && n < 200);
    // Ready left high so back-to-back writes never drive it twice in one step
    chk({30'h0, o_s_axi_bresp}, 32'h0);
    if (n >= 200) chk(32'h1, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    i_s_axi_araddr <= {20'h0, a};
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (o_s_axi_rvalid !== 1'h1 && n < 200);
    d = o_s_axi_rdata;
    // Ready left high so back-to-back reads never drive it twice in one step
    chk({30'h0, o_s_axi_rresp}, 32'h0);
    if (n >= 200) chk(32'h1, 32'h0);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    rchk(12'h014, 32'hffffffff, 32'h020002c3);
    rchk(12'h010, 32'hffffffff, 32'h010f0000);
    rchk(12'h100, 32'hffffffff, 32'h0);
  endtask
  // Four even drive codes each, every pull code and both edges; delay kept small and nonzero
  task automatic t_pad();
    logic [31:0] w;
    logic [18:0] pc; // Expected pad struct, msb first
    for (int i = 0; i < 4; i++) begin
      w = {i[7:0] + 8'h1, 8'h0, i[0], 5'h0, i[1:0], i[0], ~i[0], i[1:0], 1'h0, 2'h3 - i[1:0], 1'h0};
      wr(12'h014, w);
      rchk(12'h014, 32'hffffffff, w);
      chk({23'h0, o_rise_latch_point}, i + 2);
      chk({22'h0, o_fall_latch_half_point}, 2 * i + 3);
      pc = {w[2:0], w[5:3], w[6], w[7], w[9:8], w[15], w[31:24]};
      chk({13'h0, o_pad_ctrl}, {13'h0, pc});
    end
    wr(12'h014, 32'h020002c3);
  endtask
  task automatic t_fifo();
    i_fifo_head_data <= 32'h5a3c96e1;
    wr(12'h00c, 32'ha5c30f96);
    chk({31'h0, o_fifo_push}, 32'h1);
    chk(o_fifo_push_data, 32'ha5c30f96);
    rchk(12'h00c, 32'hffffffff, 32'h5a3c96e1);
  endtask
  // Each entry: busy response, multi-block, irq expected
  task automatic t_busy();
    logic [2:0] tbl [3];
    tbl = '{3'b000, 3'b110, 3'b101};
    foreach (tbl[k]) begin
      busy_go <= 1'h1;
      @(posedge i_clk);
      busy_go <= 1'h0;
      repeat (5) @(posedge i_clk);
      i_cmd_report <= {1'h1, tbl[k][2:1]};
      @(posedge i_clk);
      i_cmd_report <= 3'h0;
      rchk(12'h008, 32'h40, 32'h0);
      repeat (40) @(posedge i_clk);
      rchk(12'h008, 32'h40, {25'h0, tbl[k][0], 6'h0});
      rchk(12'h008, 32'h40, 32'h0);
    end
  endtask
  // Insertion with filter length one
  task automatic t_detect();
    logic [31:0] d;
    int t0;
    wr(12'h014, 32'h020002c3);
    present <= 1'h1;
    wr(12'h010, 32'h00001007);
    t0 = cyc;
    rchk(12'h010, 32'h0000f01f, 32'h0000100f);
    chk({31'h0, o_detect_input_out_on}, 32'h1);
    do rd(12'h010, d); while (d[4] !== 1'h1 && cyc - t0 < 56000);
    chk({31'h0, cyc - t0 >= 48832 && cyc - t0 <= 53000}, 32'h1);
    rchk(12'h010, 32'h10, 32'h0);
    // Removal: enables simply left on, level follows before the filter ends
    present <= 1'h0;
    repeat (4) @(posedge i_clk);
    rchk(12'h010, 32'h1f, 32'h7);
    wr(12'h010, 32'h0);
    rchk(12'h010, 32'h7, 32'h0);
    chk({31'h0, o_detect_input_out_on}, 32'h0);
  endtask

  // ====================
  // Run control
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(70000 * 20);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    t_reset();
    t_pad();
    t_fifo();
    t_busy();
    t_detect();
    print_verdict();
  end
endmodule
